// *** cru_unit.sv ***
// crc unit: byte-serial crc32/crc16 engine with automatic flash sector scan
//
// Contract
// [R01] each byte written to the input register is folded into the result at once
// [R02] software sets start sector, run enable, count, then writes control to start scan
// [R03] automatic mode treats each flash sector as 512 bytes
// [R04] processor execution is stalled until the whole scan has finished
// [R05] software clears run enable after a scan before reading the result
// [R06] result is 32 bits for poly select 0 and 16 bits for 1
// [R07] two-bit pointer picks the result byte and advances after each port access
// [R08] result holds until initialised, overwritten through the port or fed a byte
// [R09] control bits 7 to 5 read zero and ignore writes
// [R10] control bit 4 selects 32-bit 0x04C11DB7 or 16-bit 0x1021 polynomial
// [R11] writing one to control bit 3 loads the whole result with the preset
// [R12] control bit 2 chooses preset all-zeros or all-ones
// [R13] 32-bit mode: pointer 0..3 selects result bytes 0..3
// [R14] 16-bit mode: pointer 00 and 10 low byte, 01 and 11 high byte
// [R15] software follows the start write with a harmless 3-byte instruction
// [R16] 16-bit: xor byte into top bits, shift left eight times with polynomial
// [R17] 32-bit: xor byte into low byte, shift right eight times with 0xEDB88320
// [R18] scan starts at start sector times 512 and covers count sectors
// [R19] completion flag reads zero while scanning and one otherwise
// [R20] scan reads flash ascending through a read port into the same update logic
// [R21] stall is held from the start write until the final byte is folded
`timescale 1ns/10ps
module cru_unit
  import cru_pkg::*;
#(
  parameter int FLASH_ADDR_W = 15
) (
  input wire logic clk, // system clock
  input wire logic resetn, // asynchronous reset, active low
  input wire logic sfr_wr, // register write strobe
  input wire logic sfr_rd, // register read strobe
  input wire logic [7:0] sfr_addr, // register address
  input wire logic [7:0] sfr_wdata, // register write data
  output logic [7:0] sfr_rdata, // register read data
  output logic [FLASH_ADDR_W-1:0] flash_addr, // flash read address
  output logic flash_rd, // flash read request
  input wire logic [7:0] flash_rdata, // flash data, valid the cycle after flash_rd
  output logic cpu_stall // holds the processor during a scan
);

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_FOLD} cru_state_type;

  cru_ctrl_type ctrl_ff;
  logic [31:0] result_ff;
  logic [7:0] byte_in_ff;
  logic [7:0] flip_ff;
  logic auto_en_ff;
  logic [5:0] start_sector_ff;
  logic [5:0] sector_count_ff;
  cru_state_type state_ff;
  logic [FLASH_ADDR_W-1:0] addr_ff;
  logic [FLASH_ADDR_W-1:0] last_addr_ff;
  logic [31:0] nxt_result;
  logic [7:0] port_byte;
  logic wr_ctrl;
  logic wr_in;
  logic wr_flip;
  logic wr_auto;
  logic wr_count;
  logic port_acc;
  logic scan_busy;

  function automatic logic [31:0] crc_fold(input logic [31:0] acc, input logic [7:0] din, input logic sel16);
    logic [31:0] a;
    logic [15:0] b;
    a = acc ^ {24'h000000, din}; // [R17]
    b = acc[15:0] ^ {din, 8'h00}; // [R16]
    for (int i = 0; i < 8; i++) begin
      a = a[0] ? ((a >> 1) ^ CRU_POLY32_REFL) : (a >> 1);
      b = b[15] ? ((b << 1) ^ CRU_POLY16) : (b << 1);
    end
    crc_fold = sel16 ? {16'h0000, b} : a; // [R06] [R10]
  endfunction

  // one address compare shared by every strobe decode
  function automatic logic sfr_hit(input logic strobe, input logic [7:0] addr, input logic [7:0] target);
    sfr_hit = strobe && (addr == target);
  endfunction

  // byte lane picked by the pointer; 16-bit mode ignores pointer bit 1
  function automatic logic [1:0] lane(input logic [1:0] ptr, input logic sel16);
    lane = sel16 ? {1'b0, ptr[0]} : ptr; // [R13] [R14]
  endfunction

  assign wr_ctrl = sfr_hit(sfr_wr, sfr_addr, CRU_ADDR_CONTROL);
  assign wr_in = sfr_hit(sfr_wr, sfr_addr, CRU_ADDR_BYTE_INPUT);
  assign wr_flip = sfr_hit(sfr_wr, sfr_addr, CRU_ADDR_BIT_REVERSE);
  assign wr_auto = sfr_hit(sfr_wr, sfr_addr, CRU_ADDR_AUTO_SCAN);
  assign wr_count = sfr_hit(sfr_wr, sfr_addr, CRU_ADDR_SECTOR_COUNT);
  assign port_acc = sfr_hit(sfr_wr || sfr_rd, sfr_addr, CRU_ADDR_RESULT_PORT);
  // stall comes straight from the state flop, so it rises the cycle after the start write
  assign scan_busy = (state_ff != ST_IDLE);
  assign cpu_stall = scan_busy; // [R04] [R21]
  assign flash_rd = (state_ff == ST_FETCH); // [R20]
  assign flash_addr = addr_ff;
  assign port_byte = result_ff[8*lane(ctrl_ff.result_byte_pointer, ctrl_ff.poly_select) +: 8];

  // control register; a write while scanning is impossible since the cpu is held
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_ff <= cru_ctrl_type'({CRU_RST_CONTROL[CRU_BIT_POLY_SEL], CRU_RST_CONTROL[CRU_BIT_INIT_VAL:0]});
    end else if (wr_ctrl) begin
      ctrl_ff.poly_select <= sfr_wdata[CRU_BIT_POLY_SEL]; // [R09] [R10]
      ctrl_ff.init_value_select <= sfr_wdata[CRU_BIT_INIT_VAL]; // [R12]
      ctrl_ff.result_byte_pointer <= sfr_wdata[1:0];
    end else if (port_acc) begin
      ctrl_ff.result_byte_pointer <= ctrl_ff.result_byte_pointer + 2'd1; // [R07]
    end
  end

  // result: scan byte, init, software byte, port write; otherwise held
  always_comb begin
    nxt_result = result_ff; // [R08]
    if (state_ff == ST_FOLD) begin
      nxt_result = crc_fold(result_ff, flash_rdata, ctrl_ff.poly_select); // [R20]
    end else if (wr_ctrl && sfr_wdata[CRU_BIT_INIT]) begin
      nxt_result = sfr_wdata[CRU_BIT_INIT_VAL] ? CRU_PRESET_ONES : CRU_PRESET_ZERO; // [R11] [R12]
    end else if (wr_in) begin
      nxt_result = crc_fold(result_ff, sfr_wdata, ctrl_ff.poly_select); // [R01]
    end else if (sfr_wr && port_acc) begin
      nxt_result[8*lane(ctrl_ff.result_byte_pointer, ctrl_ff.poly_select) +: 8] = sfr_wdata; // [R07]
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      result_ff <= CRU_RST_RESULT;
    end else begin
      result_ff <= nxt_result;
    end
  end

  // input byte is kept only so software can read back what it wrote
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      byte_in_ff <= CRU_RST_BYTE;
    end else if (wr_in) begin
      byte_in_ff <= sfr_wdata;
    end
  end

  // bit reverse helper is stored already flipped, so the read is a plain mux
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flip_ff <= CRU_RST_BYTE;
    end else if (wr_flip) begin
      flip_ff <= {<<{sfr_wdata}};
    end
  end

  // auto control: bit 6 is status only, so its write value is dropped
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      auto_en_ff <= 1'b0;
      start_sector_ff <= CRU_RST_FIELD6;
    end else if (wr_auto) begin
      auto_en_ff <= sfr_wdata[CRU_BIT_AUTO_EN];
      start_sector_ff <= sfr_wdata[5:0];
    end
  end

  // a zero count is legal and simply starts nothing
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sector_count_ff <= CRU_RST_FIELD6;
    end else if (wr_count) begin
      sector_count_ff <= sfr_wdata[5:0];
    end
  end

  // scan sequencer: fetch one byte, fold it next cycle, step the address
  // addresses past the top of the flash window wrap; software keeps start plus count inside it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= ST_IDLE;
      addr_ff <= '0;
      last_addr_ff <= '0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          // a zero count covers nothing, so no stall is raised
          if (wr_ctrl && auto_en_ff && (sector_count_ff != 6'h00)) begin // [R02] [R05]
            state_ff <= ST_FETCH;
            addr_ff <= FLASH_ADDR_W'({start_sector_ff, 9'h000}); // [R18]
            last_addr_ff <= FLASH_ADDR_W'((({6'h00, start_sector_ff} + {6'h00, sector_count_ff})
                            << CRU_SECTOR_SHIFT) - 1); // [R03] [R18]
          end
        end
        ST_FETCH: state_ff <= ST_FOLD;
        ST_FOLD: begin
          if (addr_ff == last_addr_ff) begin
            state_ff <= ST_IDLE; // [R21]
          end else begin
            addr_ff <= addr_ff + 1'b1;
            state_ff <= ST_FETCH;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // read data registered so it is a flop output; valid the cycle after sfr_rd
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sfr_rdata <= CRU_RST_BYTE;
    end else if (sfr_rd) begin
      case (sfr_addr)
        CRU_ADDR_RESULT_PORT: sfr_rdata <= port_byte; // [R07]
        CRU_ADDR_CONTROL: sfr_rdata <= {3'b000, ctrl_ff.poly_select, 1'b0, ctrl_ff.init_value_select,
                                         ctrl_ff.result_byte_pointer}; // [R09]
        CRU_ADDR_BYTE_INPUT: sfr_rdata <= byte_in_ff;
        CRU_ADDR_BIT_REVERSE: sfr_rdata <= flip_ff;
        CRU_ADDR_AUTO_SCAN: sfr_rdata <= {auto_en_ff, !scan_busy, start_sector_ff}; // [R19]
        CRU_ADDR_SECTOR_COUNT: sfr_rdata <= {2'b00, sector_count_ff};
        default: sfr_rdata <= 8'h00;
      endcase
    end
  end

endmodule // cru_unit

// *** cru_pkg.sv ***
// package for the crc unit: register offsets, field layout, reset values and polynomials
package cru_pkg;
  localparam logic [7:0] CRU_ADDR_RESULT_PORT = 8'h91;
  localparam logic [7:0] CRU_ADDR_CONTROL = 8'h92;
  localparam logic [7:0] CRU_ADDR_BYTE_INPUT = 8'h93;
  localparam logic [7:0] CRU_ADDR_BIT_REVERSE = 8'h95;
  localparam logic [7:0] CRU_ADDR_AUTO_SCAN = 8'h96;
  localparam logic [7:0] CRU_ADDR_SECTOR_COUNT = 8'h97;
  localparam int CRU_BIT_POLY_SEL = 4;
  localparam int CRU_BIT_INIT = 3;
  localparam int CRU_BIT_INIT_VAL = 2;
  localparam int CRU_BIT_AUTO_EN = 7;
  localparam int CRU_BIT_AUTO_DONE = 6;
  localparam logic [7:0] CRU_RST_CONTROL = 8'h00;
  localparam logic [7:0] CRU_RST_BYTE = 8'h00;
  localparam logic [5:0] CRU_RST_FIELD6 = 6'h00;
  localparam logic [31:0] CRU_RST_RESULT = 32'h00000000;
  localparam logic [31:0] CRU_PRESET_ZERO = 32'h00000000;
  localparam logic [31:0] CRU_PRESET_ONES = 32'hffffffff;
  localparam logic [31:0] CRU_POLY32_REFL = 32'hedb88320;
  localparam logic [15:0] CRU_POLY16 = 16'h1021;
  localparam int CRU_SECTOR_BYTES = 512;
  localparam int CRU_SECTOR_SHIFT = 9;

  typedef struct packed {
    logic poly_select;
    logic init_value_select;
    logic [1:0] result_byte_pointer;
  } cru_ctrl_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cru_sfr_req_type;
endpackage

// *** cru_unit_sva.sv ***
// assertions for the crc unit, bound to its ports
`timescale 1ns/10ps
module cru_unit_sva
  import cru_pkg::*;
#(
  parameter int FLASH_ADDR_W = 15
) (
  input wire logic clk, // clock
  input wire logic resetn, // reset
  input wire logic sfr_wr, // write
  input wire logic sfr_rd, // read
  input wire logic [7:0] sfr_addr, // address
  input wire logic [7:0] sfr_wdata, // wdata
  input wire logic [7:0] sfr_rdata, // rdata
  input wire logic [FLASH_ADDR_W-1:0] flash_addr, // fetch addr
  input wire logic flash_rd, // fetch
  input wire logic [7:0] flash_rdata, // fetch data
  input wire logic cpu_stall // stall
);
  logic en_ff;
  logic [5:0] st_ff;
  logic [5:0] cnt_ff;
  logic [15:0] n_ff;
  logic go;
  // shadow of the scan setup, so start and length can be judged from the bus alone
  assign go = sfr_wr && sfr_addr == CRU_ADDR_CONTROL && en_ff && cnt_ff != 6'h00 && !cpu_stall;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {en_ff, st_ff, cnt_ff, n_ff} <= '0;
    end else begin
      if (sfr_wr && sfr_addr == CRU_ADDR_AUTO_SCAN)
        {en_ff, st_ff} <= {sfr_wdata[7], sfr_wdata[5:0]};
      if (sfr_wr && sfr_addr == CRU_ADDR_SECTOR_COUNT)
        cnt_ff <= sfr_wdata[5:0];
      n_ff <= go ? 16'h0 : n_ff + 16'(flash_rd);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_ctrl_unused_zero: assert property (sfr_rd && sfr_addr == CRU_ADDR_CONTROL |=> sfr_rdata[7:5] == 3'h0)
    else $error("control spare bits set");
  a_done_when_idle: assert property (sfr_rd && sfr_addr == CRU_ADDR_AUTO_SCAN && !cpu_stall |=> sfr_rdata[6])
    else $error("done flag low while idle");
  a_scan_start_addr: assert property (go |=> cpu_stall && flash_rd && flash_addr == {st_ff, 9'h000})
    else $error("scan start wrong");
  a_stall_has_cause: assert property ($rose(cpu_stall) |-> $past(go))
    else $error("stall without start");
  a_fetch_spacing: assert property (flash_rd |=> (!flash_rd && cpu_stall) ##1 (flash_rd == cpu_stall))
    else $error("fetch spacing wrong");
  a_addr_ascend: assert property (flash_rd ##2 flash_rd |-> flash_addr == $past(flash_addr, 2) + 1'b1)
    else $error("fetch address not ascending");
  a_sector_bytes: assert property ($fell(cpu_stall) |-> n_ff == {cnt_ff, 9'h000})
    else $error("scan byte count wrong");
  a_stall_end_fold: assert property ($fell(cpu_stall) |-> $past(flash_rd, 2) && !$past(flash_rd))
    else $error("stall end misplaced");
  c_scan_go: cover property (go);
  c_scan_end: cover property ($fell(cpu_stall));
  c_ctrl_read: cover property (sfr_rd && sfr_addr == CRU_ADDR_CONTROL);
endmodule // cru_unit_sva
bind cru_unit cru_unit_sva #(.FLASH_ADDR_W(FLASH_ADDR_W)) u_sva (.clk(clk), .resetn(resetn), .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .flash_addr(flash_addr),
  .flash_rd(flash_rd), .flash_rdata(flash_rdata), .cpu_stall(cpu_stall));

// *** cru_flash_model.sv ***
// flash read port model
`timescale 1ns/10ps
module cru_flash_model (
  input wire logic clk, // clock
  input wire logic flash_rd, // fetch
  input wire logic [14:0] flash_addr, // byte address
  output logic [7:0] flash_rdata // valid the cycle after a fetch
);
  initial flash_rdata = 8'h00;
  // toggles outside the fetch window so a late sample cannot pass by luck
  always @(posedge clk)
    flash_rdata <= flash_rd ? flash_addr[7:0] ^ flash_addr[14:7] : ~flash_rdata;
endmodule // cru_flash_model

// *** tb.sv ***
// crc unit testbench
`timescale 1ns/10ps
module tb;
  import cru_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, flash_rd, cpu_stall;
  logic [7:0] sfr_addr = 8'h0, sfr_wdata = 8'h0, sfr_rdata, flash_rdata, v;
  logic [14:0] flash_addr, fa;
  logic [15:0] lfsr = 16'hf36d;
  logic [31:0] exp;
  int err_count = 0, checks_done = 0;
  always #10 clk = ~clk;
  cru_unit dut (.clk(clk), .resetn(resetn), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .flash_addr(flash_addr), .flash_rd(flash_rd),
    .flash_rdata(flash_rdata), .cpu_stall(cpu_stall));
  cru_flash_model fm (.clk(clk), .flash_rd(flash_rd), .flash_addr(flash_addr), .flash_rdata(flash_rdata));
  function automatic logic [31:0] step(logic [31:0] a, logic [7:0] b, logic p);
    a ^= p ? {16'h0, b, 8'h0} : {24'h0, b};
    for (int i = 0; i < 8; i++)
      a = p ? {16'h0, a[14:0], 1'b0} ^ {16'h0, {16{a[15]}} & 16'h1021} : (a >> 1) ^ ({32{a[0]}} & 32'hedb88320);
    return a;
  endfunction
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask
  // every access waits an extra edge so the registered read data has landed
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_wr <= w;
    sfr_rd <= !w;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge clk);
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b0;
    @(posedge clk);
    #1 v = sfr_rdata;
  endtask
  task automatic rd4(input logic p);
    for (int k = 0; k < 4; k++) begin
      acc(1'b0, CRU_ADDR_RESULT_PORT, 8'h0);
      chk("result", v, exp[8 * (p ? k % 2 : k) +: 8]);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    acc(1'b0, CRU_ADDR_CONTROL, 8'h0);
    chk("ctrl", v, 32'h0);
    acc(1'b0, CRU_ADDR_AUTO_SCAN, 8'h0);
    chk("auto", v, 32'h40);
    for (int m = 3; m >= 0; m--) begin
      exp = {32{m[0]}};
      acc(1'b1, CRU_ADDR_CONTROL, {3'h7, m[1], 1'b1, m[0], 2'h0});
      for (int k = 0; k < 4; k++) begin
        v = k == 0 ? 8'h63 : lfsr[7:0];
        lfsr = lfsr_next(lfsr);
        exp = step(exp, v, m[1]);
        acc(1'b1, CRU_ADDR_BYTE_INPUT, v);
      end
      rd4(m[1]);
      acc(1'b0, CRU_ADDR_CONTROL, 8'h0);
      chk("ctrl", v, {3'h0, m[1], 1'b0, m[0], 2'h0});
      acc(1'b1, CRU_ADDR_RESULT_PORT, 8'h5a);
      exp[7:0] = 8'h5a;
      acc(1'b1, CRU_ADDR_CONTROL, {3'h0, m[1], 1'b0, m[0], 2'h0});
      rd4(m[1]);
    end
    acc(1'b1, CRU_ADDR_AUTO_SCAN, {2'h2, lfsr[5:0]});
    acc(1'b1, CRU_ADDR_CONTROL, 8'h0c);
    chk("idle", cpu_stall, 32'h0);
    acc(1'b1, CRU_ADDR_SECTOR_COUNT, 8'h01);
    acc(1'b1, CRU_ADDR_CONTROL, 8'h00);
    chk("stall", cpu_stall, 32'h1);
    for (int n = 0; cpu_stall !== 1'b0; n++) begin
      if (n > 1100) begin
        err_count++;
        close_out();
      end
      @(posedge clk);
      #1;
    end
    acc(1'b1, CRU_ADDR_BIT_REVERSE, 8'hc0);
    acc(1'b0, CRU_ADDR_BIT_REVERSE, 8'h0);
    chk("flip", v, 32'h03);
    exp = 32'hffffffff;
    for (int a = 0; a < 512; a++) begin
      fa = {lfsr[5:0], 9'h0} + 15'(a);
      exp = step(exp, fa[7:0] ^ fa[14:7], 1'b0);
    end
    acc(1'b1, CRU_ADDR_AUTO_SCAN, {2'h0, lfsr[5:0]});
    acc(1'b0, CRU_ADDR_AUTO_SCAN, 8'h0);
    chk("auto", v, {2'h1, lfsr[5:0]});
    rd4(1'b0);
    close_out();
  end
endmodule // tb
